// ===== dp_steer_pkg.sv
package dp_steer_pkg;

  localparam int DATA_W = 64;
  localparam int ADDR_W = 4;
  localparam int COEF_W = 6;
  localparam int SUM_W = 8;
  localparam int CKSEL_W = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CKSEL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FIR = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BYP_RX = 2;
  localparam int CTRL_BYP_TX = 3;
  localparam int CTRL_LPBK = 4;
  localparam int CTRL_MON_REQ = 5;
  localparam int CTRL_MON_UNITY = 6;
  localparam int CTRL_AN_EN = 7;
  localparam int CTRL_AN_FORCE = 8;
  localparam int CTRL_AN_F10G = 9;
  localparam logic [31:0] CTRL_RST = 32'h0000_000C;

  // Clock output select fields
  localparam int CKSEL0_LSB = 0;
  localparam int CKSEL1_LSB = 4;
  localparam logic [31:0] CKSEL_RST = 32'h0000_0010;

  // FIR coefficient fields
  localparam int FIR_PRE_LSB = 0;
  localparam int FIR_MAIN_LSB = 8;
  localparam int FIR_POST_LSB = 16;
  localparam logic [31:0] FIR_RST = 32'h0000_1000;

  // Status fields
  localparam int STS_MODE_LSB = 0;
  localparam int STS_FLUSH = 2;
  localparam int STS_REF125 = 3;
  localparam int STS_CRU10G = 4;
  localparam int STS_AN_GOOD = 5;
  localparam int STS_MON_ACT = 6;
  localparam int STS_AN_LSB = 8;

  // Reference strap codes
  localparam logic [1:0] STRAP_156M25 = 2'h0;
  localparam logic [1:0] STRAP_125M = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int FLUSH_NS = 400;
  localparam int FLUSH_CYC =
    (FLUSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLUSH_W = 5;

  typedef enum logic [1:0] {MODE_LAN, MODE_WAN, MODE_1G} mode_t;
  typedef enum logic [1:0] {RATE_10G3, RATE_9G95, RATE_1G25} rate_t;
  typedef enum logic [2:0] {AN_OFF, AN_LISTEN, AN_TRAIN, AN_GOOD} an_t;

  typedef struct packed {
    logic vld;
    logic [DATA_W-1:0] dat;
  } word_t;

  typedef struct packed {
    logic vld;
    logic is_10g;
  } rate_ev_t;

endpackage : dp_steer_pkg

// ===== phy_mode_datapath_steering.sv
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
module phy_mode_datapath_steering
  import dp_steer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [1:0] strap_mode_i,
  input wire word_t serial_rx_input_i,
  input wire word_t wis_rx_payload_i,
  input wire word_t line_pcs_dec_i,
  input wire word_t proc_rx_ret_i,
  input wire word_t serial_host_rx_i,
  input wire word_t host_pcs_dec_i,
  input wire word_t proc_tx_ret_i,
  input wire word_t line_pcs_enc_i,
  input wire word_t wis_tx_frame_i,
  input wire rate_ev_t rate_det_i,
  input wire rate_ev_t an_partner_i,
  input wire logic train_done_i,
  input wire logic link_lost_i,
  output word_t elastic_wr_o,
  output word_t wis_rx_o,
  output word_t pcs10_rx_o,
  output word_t pcs1g_rx_o,
  output word_t proc_rx_o,
  output word_t host_pcs10_enc_o,
  output word_t host_pcs1g_enc_o,
  output word_t host_pcs10_dec_o,
  output word_t host_pcs1g_dec_o,
  output word_t proc_tx_o,
  output word_t line_pcs10_enc_o,
  output word_t line_pcs1g_enc_o,
  output word_t wis_tx_o,
  output word_t serial_tx_output_o,
  output logic wis_en_o,
  output logic pcs_rst_o,
  output rate_t line_rate_o,
  output rate_t host_rate_o,
  output logic ref_125_o,
  output logic cru_10g_o,
  output logic [CKSEL_W-1:0] clk_out0_sel_o,
  output logic [CKSEL_W-1:0] clk_out1_sel_o,
  output logic mon_active_o,
  output logic adapt_en_o,
  output logic dfe_zero_o,
  output logic train_en_o,
  output logic signed [SUM_W-1:0] fir_sum_o
);

  typedef struct packed {
    logic wait_r;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] cksel;
    logic [31:0] fir;
    mode_t act_mode;
    logic [FLUSH_W-1:0] flush_cnt;
    logic strap_done;
    logic ref_125;
    an_t an_st;
    logic cru_10g;
    word_t eb;
    word_t wis_rx;
    word_t pcs10_rx;
    word_t pcs1g_rx;
    word_t proc_rx;
    word_t host10_enc;
    word_t host1g_enc;
    word_t host10_dec;
    word_t host1g_dec;
    word_t proc_tx;
    word_t line10_enc;
    word_t line1g_enc;
    word_t wis_tx;
    word_t ser;
    logic [2:0] fir_sh;
    logic signed [SUM_W-1:0] fir_sum;
    rate_t line_rate;
    logic mon_act;
    logic adapt_en;
    logic dfe_zero;
    logic wis_en;
    logic pcs_rst;
    rate_t host_rate;
    logic train_en;
  } st_t;

  localparam word_t IDLE_W = '0;

  st_t st_r;
  st_t st_nxt;

  logic [31:0] mask;
  logic [31:0] sts;
  logic flushing;
  logic is10g;
  word_t core_rx;
  word_t core_tx;
  logic signed [SUM_W-1:0] coef [3];
  logic signed [SUM_W-1:0] acc;

  always_comb
  begin
    st_nxt = st_r;
    mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
            {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    flushing = (st_r.flush_cnt != '0);
    is10g = (st_r.act_mode != MODE_1G);

    sts = '0;
    sts[STS_MODE_LSB +: 2] = st_r.act_mode;
    sts[STS_FLUSH] = flushing;
    sts[STS_REF125] = st_r.ref_125;
    sts[STS_CRU10G] = st_r.cru_10g;
    sts[STS_AN_GOOD] = (st_r.an_st == AN_GOOD);
    sts[STS_MON_ACT] = st_r.mon_act;
    sts[STS_AN_LSB +: 3] = st_r.an_st;

    // Bus slave: answer one cycle after the request, act on release edge
    if ((avs_read_i || avs_write_i) && st_r.wait_r)
    begin
      st_nxt.wait_r = 1'b0;
      if (avs_address_i == OFS_CTRL)
        st_nxt.rdata = st_r.ctrl;
      else if (avs_address_i == OFS_CKSEL)
        st_nxt.rdata = st_r.cksel;
      else if (avs_address_i == OFS_FIR)
        st_nxt.rdata = st_r.fir;
      else if (avs_address_i == OFS_STATUS)
        st_nxt.rdata = sts;
      else
        st_nxt.rdata = '0;
    end
    else
    begin
      st_nxt.wait_r = 1'b1;
    end

    if (avs_write_i && !st_r.wait_r)
    begin
      if (avs_address_i == OFS_CTRL)
      begin
        st_nxt.ctrl = (st_r.ctrl & ~mask) | (avs_writedata_i & mask);
        // An undefined mode code is not taken
        if (st_nxt.ctrl[CTRL_MODE_LSB +: 2] == 2'h3)
          st_nxt.ctrl[CTRL_MODE_LSB +: 2] =
            st_r.ctrl[CTRL_MODE_LSB +: 2];
      end
      else if (avs_address_i == OFS_CKSEL)
        st_nxt.cksel = (st_r.cksel & ~mask) | (avs_writedata_i & mask);
      else if (avs_address_i == OFS_FIR)
        st_nxt.fir = (st_r.fir & ~mask) | (avs_writedata_i & mask);
    end

    // Reference rate strap, caught once after reset release
    if (!st_r.strap_done)
    begin
      st_nxt.strap_done = 1'b1;
      st_nxt.ref_125 = (strap_mode_i == STRAP_125M);
    end

    // Mode change: hold routing idle and PCS in reset, then switch
    if (flushing)
    begin
      st_nxt.flush_cnt = st_r.flush_cnt - 1'b1;
      if (st_r.flush_cnt == FLUSH_W'(1))
        st_nxt.act_mode = mode_t'(st_r.ctrl[CTRL_MODE_LSB +: 2]);
    end
    else if (st_r.ctrl[CTRL_MODE_LSB +: 2] != st_r.act_mode)
    begin
      st_nxt.flush_cnt = FLUSH_W'(FLUSH_CYC);
    end

    // Negotiation engine, no software steps needed
    case (st_r.an_st)
      AN_OFF:
      begin
        if (st_r.ctrl[CTRL_AN_EN] && !st_r.ctrl[CTRL_AN_FORCE])
          st_nxt.an_st = AN_LISTEN;
      end
      AN_LISTEN:
      begin
        if (an_partner_i.vld)
        begin
          // Common ability resolved with 10G ahead of 1G
          st_nxt.cru_10g = an_partner_i.is_10g;
          st_nxt.an_st = an_partner_i.is_10g ? AN_TRAIN : AN_GOOD;
        end
        else if (rate_det_i.vld)
        begin
          st_nxt.cru_10g = rate_det_i.is_10g;
          st_nxt.an_st = AN_GOOD;
        end
      end
      AN_TRAIN:
      begin
        if (train_done_i)
          st_nxt.an_st = AN_GOOD;
        else if (link_lost_i)
          st_nxt.an_st = AN_LISTEN;
      end
      AN_GOOD:
      begin
        if (link_lost_i)
          st_nxt.an_st = AN_LISTEN;
      end
      default:
      begin
        st_nxt.an_st = AN_OFF;
      end
    endcase
    if (!st_r.ctrl[CTRL_AN_EN] || st_r.ctrl[CTRL_AN_FORCE])
      st_nxt.an_st = AN_OFF;

    // Clock recovery rate: forced, negotiated or auto-detected
    if (st_r.ctrl[CTRL_AN_EN] && st_r.ctrl[CTRL_AN_FORCE])
      st_nxt.cru_10g = st_r.ctrl[CTRL_AN_F10G];
    else if (!st_r.ctrl[CTRL_AN_EN] && rate_det_i.vld)
      st_nxt.cru_10g = rate_det_i.is_10g;

    // Signal monitor gating and unity gain setup
    st_nxt.mon_act = st_r.ctrl[CTRL_MON_REQ] && is10g;
    st_nxt.adapt_en = !(st_nxt.mon_act && st_r.ctrl[CTRL_MON_UNITY]);
    st_nxt.dfe_zero = st_nxt.mon_act && st_r.ctrl[CTRL_MON_UNITY];

    // Ingress: deserialized words to elastic buffer, then to the receive path of the mode
    st_nxt.eb = serial_rx_input_i;
    st_nxt.wis_rx = IDLE_W;
    st_nxt.pcs10_rx = IDLE_W;
    st_nxt.pcs1g_rx = IDLE_W;
    case (st_r.act_mode)
      MODE_WAN:
      begin
        st_nxt.wis_rx = st_r.eb;
        st_nxt.pcs10_rx = wis_rx_payload_i;
      end
      MODE_LAN:
      begin
        st_nxt.pcs10_rx = st_r.eb;
      end
      default:
      begin
        st_nxt.pcs1g_rx = st_r.eb;
      end
    endcase

    // Optional processing, receive direction
    if (st_r.ctrl[CTRL_BYP_RX])
    begin
      st_nxt.proc_rx = IDLE_W;
      core_rx = line_pcs_dec_i;
    end
    else
    begin
      st_nxt.proc_rx = line_pcs_dec_i;
      core_rx = proc_rx_ret_i;
    end
    st_nxt.host10_enc = is10g ? core_rx : IDLE_W;
    st_nxt.host1g_enc = is10g ? IDLE_W : core_rx;

    // Egress: host words to the host decoder of the mode
    st_nxt.host10_dec = is10g ? serial_host_rx_i : IDLE_W;
    st_nxt.host1g_dec = is10g ? IDLE_W : serial_host_rx_i;

    // Optional processing, transmit direction
    if (st_r.ctrl[CTRL_BYP_TX])
    begin
      st_nxt.proc_tx = IDLE_W;
      core_tx = host_pcs_dec_i;
    end
    else
    begin
      st_nxt.proc_tx = host_pcs_dec_i;
      core_tx = proc_tx_ret_i;
    end
    st_nxt.line10_enc = is10g ? core_tx : IDLE_W;
    st_nxt.line1g_enc = is10g ? IDLE_W : core_tx;

    // WAN framer input and serializer source
    st_nxt.wis_tx = (st_r.act_mode == MODE_WAN) ? line_pcs_enc_i
                                                 : IDLE_W;
    if (st_r.ctrl[CTRL_LPBK])
      st_nxt.ser = st_r.eb;
    else if (st_r.act_mode == MODE_WAN)
      st_nxt.ser = wis_tx_frame_i;
    else
      st_nxt.ser = line_pcs_enc_i;

    case (st_r.act_mode)
      MODE_WAN:
        st_nxt.line_rate = RATE_9G95;
      MODE_LAN:
        st_nxt.line_rate = RATE_10G3;
      default:
        st_nxt.line_rate = RATE_1G25;
    endcase

    if (flushing)
    begin
      st_nxt.wis_rx = IDLE_W;
      st_nxt.pcs10_rx = IDLE_W;
      st_nxt.pcs1g_rx = IDLE_W;
      st_nxt.proc_rx = IDLE_W;
      st_nxt.host10_enc = IDLE_W;
      st_nxt.host1g_enc = IDLE_W;
      st_nxt.host10_dec = IDLE_W;
      st_nxt.host1g_dec = IDLE_W;
      st_nxt.proc_tx = IDLE_W;
      st_nxt.line10_enc = IDLE_W;
      st_nxt.line1g_enc = IDLE_W;
      st_nxt.wis_tx = IDLE_W;
      st_nxt.ser = IDLE_W;
    end

    // Decodes taken from the settled next state so outputs stay registered
    st_nxt.wis_en = (st_nxt.line_rate == RATE_9G95);
    st_nxt.pcs_rst = (st_nxt.flush_cnt != '0);
    // Host side stays at the LAN rate in WAN mode
    st_nxt.host_rate = (st_nxt.line_rate == RATE_1G25) ? RATE_1G25
                                                       : RATE_10G3;
    st_nxt.train_en = (st_nxt.an_st == AN_TRAIN);

    // Three tap output filter on the transmitted bit stream
    st_nxt.fir_sh = {st_r.fir_sh[1:0], st_r.ser.dat[0]};
    coef[0] = SUM_W'($signed(st_r.fir[FIR_PRE_LSB +: COEF_W]));
    coef[1] = SUM_W'($signed(st_r.fir[FIR_MAIN_LSB +: COEF_W]));
    coef[2] = SUM_W'($signed(st_r.fir[FIR_POST_LSB +: COEF_W]));
    acc = '0;
    for (int i = 0; i < 3; i++)
    begin
      // Newest bit is the pre-cursor, oldest the post-cursor
      if (st_r.fir_sh[i])
        acc = acc + coef[i];
      else
        acc = acc - coef[i];
    end
    st_nxt.fir_sum = acc;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st_r <= '0;
      st_r.wait_r <= 1'b1;
      st_r.ctrl <= CTRL_RST;
      st_r.cksel <= CKSEL_RST;
      st_r.fir <= FIR_RST;
      st_r.act_mode <= MODE_LAN;
      st_r.an_st <= AN_OFF;
      st_r.cru_10g <= 1'b1;
      st_r.line_rate <= RATE_10G3;
      st_r.adapt_en <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_o = st_r.rdata;
  assign avs_waitrequest_o = st_r.wait_r;
  assign elastic_wr_o = st_r.eb;
  assign wis_rx_o = st_r.wis_rx;
  assign pcs10_rx_o = st_r.pcs10_rx;
  assign pcs1g_rx_o = st_r.pcs1g_rx;
  assign proc_rx_o = st_r.proc_rx;
  assign host_pcs10_enc_o = st_r.host10_enc;
  assign host_pcs1g_enc_o = st_r.host1g_enc;
  assign host_pcs10_dec_o = st_r.host10_dec;
  assign host_pcs1g_dec_o = st_r.host1g_dec;
  assign proc_tx_o = st_r.proc_tx;
  assign line_pcs10_enc_o = st_r.line10_enc;
  assign line_pcs1g_enc_o = st_r.line1g_enc;
  assign wis_tx_o = st_r.wis_tx;
  assign serial_tx_output_o = st_r.ser;
  assign wis_en_o = st_r.wis_en;
  assign pcs_rst_o = st_r.pcs_rst;
  assign line_rate_o = st_r.line_rate;
  assign host_rate_o = st_r.host_rate;
  assign ref_125_o = st_r.ref_125;
  assign cru_10g_o = st_r.cru_10g;
  assign clk_out0_sel_o = st_r.cksel[CKSEL0_LSB +: CKSEL_W];
  assign clk_out1_sel_o = st_r.cksel[CKSEL1_LSB +: CKSEL_W];
  assign mon_active_o = st_r.mon_act;
  assign adapt_en_o = st_r.adapt_en;
  assign dfe_zero_o = st_r.dfe_zero;
  assign train_en_o = st_r.train_en;
  assign fir_sum_o = st_r.fir_sum;

endmodule : phy_mode_datapath_steering

// ===== dp_steer_monitor.sv
module dp_steer_monitor
  import dp_steer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire word_t serial_rx_input_i,
  input wire word_t wis_rx_payload_i,
  input wire word_t elastic_wr_o,
  input wire word_t pcs10_rx_o,
  input wire word_t serial_tx_output_o,
  input wire logic pcs_rst_o,
  input wire logic wis_en_o,
  input wire rate_t line_rate_o,
  input wire rate_t host_rate_o,
  input wire logic mon_active_o,
  input wire logic adapt_en_o,
  input wire logic dfe_zero_o
);
  logic [5:0] fl_cnt_r;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  // Counts consecutive flush cycles
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || !pcs_rst_o)
      fl_cnt_r <= '0;
    else
      fl_cnt_r <= fl_cnt_r + 6'h1;
  end

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_quiet;
    !$past(srst_i) && !pcs_rst_o && !$past(pcs_rst_o) && $stable(line_rate_o);
  endsequence

  chk_bus_answer: assert property (s_req |=> !avs_waitrequest_o)
    else $error("waitrequest not low one cycle after request");
  chk_elastic_delay:
    assert property (!$past(srst_i) |->
      elastic_wr_o == $past(serial_rx_input_i))
    else $error("elastic write not one cycle behind input");
  chk_flush_len:
    assert property ($fell(pcs_rst_o) |-> fl_cnt_r == 6'(FLUSH_CYC))
    else $error("flush length wrong");
  chk_flush_quiet:
    assert property (pcs_rst_o && $past(pcs_rst_o) |->
      pcs10_rx_o == word_t'(0) && serial_tx_output_o == word_t'(0))
    else $error("traffic during flush");
  chk_lan_route:
    assert property (s_quiet ##0 line_rate_o == RATE_10G3 |->
      pcs10_rx_o == $past(elastic_wr_o))
    else $error("lan receive route wrong");
  chk_wan_route:
    assert property (s_quiet ##0 line_rate_o == RATE_9G95 |->
      pcs10_rx_o == $past(wis_rx_payload_i))
    else $error("wan receive route wrong");
  chk_wan_rate:
    assert property (line_rate_o == RATE_9G95 |->
      host_rate_o == RATE_10G3 && wis_en_o)
    else $error("wan rates or enable wrong");
  chk_mon_gate:
    assert property (line_rate_o == RATE_1G25 &&
      $past(line_rate_o) == RATE_1G25 |-> !mon_active_o)
    else $error("monitor active in 1G");
  chk_unity_taps:
    assert property (dfe_zero_o |-> !adapt_en_o && line_rate_o != RATE_1G25)
    else $error("unity gain taps wrong");
endmodule : dp_steer_monitor

bind phy_mode_datapath_steering dp_steer_monitor u_steer_mon (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .serial_rx_input_i(serial_rx_input_i), .wis_rx_payload_i(wis_rx_payload_i),
  .elastic_wr_o(elastic_wr_o), .pcs10_rx_o(pcs10_rx_o),
  .serial_tx_output_o(serial_tx_output_o), .pcs_rst_o(pcs_rst_o),
  .wis_en_o(wis_en_o), .line_rate_o(line_rate_o), .host_rate_o(host_rate_o),
  .mon_active_o(mon_active_o), .adapt_en_o(adapt_en_o),
  .dfe_zero_o(dfe_zero_o)
);

// ===== link_partner_model.sv
module link_partner_model
  import dp_steer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic en_i,
  output word_t line_o = '0,
  output word_t wan_o = '0,
  output word_t host_o = '0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] cnt_r = '0;

  // Idle lanes toggle every cycle so a stale word never looks live
  always @(posedge clk_sys_i)
  begin
    cnt_r <= en_i ? cnt_r + 64'h1 : ~cnt_r;
    line_o <= '{en_i, cnt_r};
    wan_o <= '{en_i, cnt_r ^ 64'hA5A5};
    host_o <= '{en_i, ~cnt_r};
  end
endmodule : link_partner_model

// ===== phy_mode_datapath_steering_bench.sv
module phy_mode_datapath_steering_bench
  import dp_steer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, p_en = 1'b0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic [1:0] strap_mode_i = STRAP_125M;
  rate_ev_t rate_det_i = '0;
  word_t line_w, wan_w, host_w, elastic_wr_o, wis_rx_o, pcs10_rx_o;
  word_t pcs1g_rx_o, serial_tx_output_o;
  logic avs_waitrequest_o, wis_en_o, pcs_rst_o, ref_125_o, cru_10g_o;
  logic mon_active_o, adapt_en_o, dfe_zero_o;
  rate_ev_t an_partner_i = '0;
  logic train_done_i = 1'b0, link_lost_i = 1'b0, train_en_o;
  word_t proc_rx_o, proc_tx_o, host_pcs10_enc_o, line_pcs10_enc_o;
  logic signed [SUM_W-1:0] fir_sum_o;
  rate_t line_rate_o, host_rate_o;
  logic [CKSEL_W-1:0] clk_out0_sel_o, clk_out1_sel_o;
  int err_count = 0;
  int checks_done = 0;

  link_partner_model partner (.clk_sys_i(clk_sys_i), .en_i(p_en),
    .line_o(line_w), .wan_o(wan_w), .host_o(host_w));

  phy_mode_datapath_steering uut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .strap_mode_i(strap_mode_i), .serial_rx_input_i(line_w),
    .wis_rx_payload_i(wan_w), .line_pcs_dec_i(line_w), .proc_rx_ret_i(line_w),
    .serial_host_rx_i(host_w), .host_pcs_dec_i(host_w),
    .proc_tx_ret_i(host_w), .line_pcs_enc_i(host_w), .wis_tx_frame_i(wan_w),
    .rate_det_i(rate_det_i), .an_partner_i(an_partner_i),
    .train_done_i(train_done_i), .link_lost_i(link_lost_i),
    .elastic_wr_o(elastic_wr_o), .wis_rx_o(wis_rx_o),
    .pcs10_rx_o(pcs10_rx_o), .pcs1g_rx_o(pcs1g_rx_o),
    .proc_rx_o(proc_rx_o), .host_pcs10_enc_o(host_pcs10_enc_o),
    .host_pcs1g_enc_o(), .host_pcs10_dec_o(),
    .host_pcs1g_dec_o(), .proc_tx_o(proc_tx_o),
    .line_pcs10_enc_o(line_pcs10_enc_o),
    .line_pcs1g_enc_o(), .wis_tx_o(), .serial_tx_output_o(serial_tx_output_o),
    .wis_en_o(wis_en_o), .pcs_rst_o(pcs_rst_o), .line_rate_o(line_rate_o),
    .host_rate_o(host_rate_o), .ref_125_o(ref_125_o), .cru_10g_o(cru_10g_o),
    .clk_out0_sel_o(clk_out0_sel_o), .clk_out1_sel_o(clk_out1_sel_o),
    .mon_active_o(mon_active_o), .adapt_en_o(adapt_en_o),
    .dfe_zero_o(dfe_zero_o), .train_en_o(train_en_o),
    .fir_sum_o(fir_sum_o)
  );

  initial
  begin
    // One clock stands for both always present reference clocks
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic cmp(input string nm, input logic [64:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    n = 0;
    // Sampled at the rising edge, before the slave updates its outputs
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    if (avs_waitrequest_o !== 1'b0)
      err_count++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic t_regs;
    logic [31:0] q;
    bus(1'b0, OFS_CTRL, '0, q);
    cmp("ctrl", CTRL_RST, q);
    bus(1'b0, OFS_FIR, '0, q);
    cmp("fir", FIR_RST, q);
    bus(1'b0, OFS_CKSEL, '0, q);
    cmp("cksel", CKSEL_RST, q);
    bus(1'b1, OFS_CKSEL, 32'h52, q);
    @(negedge clk_sys_i);
    cmp("clk out0", 3'h2, clk_out0_sel_o);
    cmp("clk out1", 3'h5, clk_out1_sel_o);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, q);
    bus(1'b0, 4'h2, '0, q);
    cmp("unmapped", 32'h0, q);
    bus(1'b1, OFS_CTRL, 32'hF, q);
    bus(1'b1, OFS_STATUS, 32'h3, q);
    bus(1'b0, OFS_STATUS, '0, q);
    cmp("sts mode", 2'h0, q[1:0]);
    cmp("sts ref", 1'b1, q[STS_REF125]);
    cmp("ref pin", 1'b1, ref_125_o);
    cmp("no flush", 1'b0, pcs_rst_o);
    $display("register test done");
  endtask : t_regs

  task automatic t_mode(input logic [1:0] m, input rate_t r);
    logic [31:0] q;
    word_t w, v, h;
    int n;
    bus(1'b1, OFS_CTRL, 32'hC | 32'(m), q);
    @(negedge clk_sys_i);
    for (n = 0; n < 4 && pcs_rst_o !== 1'b1; n++) @(negedge clk_sys_i);
    for (n = 0; n < 40 && pcs_rst_o === 1'b1; n++) @(negedge clk_sys_i);
    cmp("flush cycles", 32'(FLUSH_CYC), n);
    // Line rate follows the new mode one edge later
    @(negedge clk_sys_i);
    cmp("line rate", r, line_rate_o);
    cmp("host rate", m == 2'h1 ? RATE_10G3 : r, host_rate_o);
    cmp("wis en", m == 2'h1, wis_en_o);
    w = line_w;
    v = wan_w;
    h = host_w;
    @(negedge clk_sys_i);
    if (m == 2'h1) cmp("pcs10 wan", v, pcs10_rx_o);
    cmp("serial tx", m == 2'h1 ? v : h, serial_tx_output_o);
    @(negedge clk_sys_i);
    if (m == 2'h0) cmp("pcs10 lan", w, pcs10_rx_o);
    if (m == 2'h1) cmp("wis rx", w, wis_rx_o);
    if (m == 2'h2) cmp("pcs1g", w, pcs1g_rx_o);
    bus(1'b0, OFS_STATUS, '0, q);
    cmp("sts mode", m, q[1:0]);
    $display("mode %0d test done", m);
  endtask : t_mode

  task automatic t_mon(input logic [1:0] m, input logic on);
    logic [31:0] q;
    bus(1'b1, OFS_CTRL, 32'h6C | 32'(m), q);
    repeat (2) @(negedge clk_sys_i);
    cmp("mon active", on, mon_active_o);
    cmp("dfe zero", on, dfe_zero_o);
    cmp("adapt", !on, adapt_en_o);
    $display("monitor test done");
  endtask : t_mon

  task automatic t_rate;
    int n;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk_sys_i);
      rate_det_i <= '{1'b1, b[0]};
      @(posedge clk_sys_i);
      rate_det_i <= '{1'b0, 1'b0};
      for (n = 0; n < 8 && cru_10g_o !== b[0]; n++) @(negedge clk_sys_i);
      cmp("cru rate", b[0], cru_10g_o);
    end
    $display("rate test done");
  endtask : t_rate

  task automatic t_strap;
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    strap_mode_i <= STRAP_156M25;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
    cmp("ref pin", 1'b0, ref_125_o);
    $display("strap test done");
  endtask : t_strap

  task automatic t_path;
    logic [31:0] q;
    word_t w, h;
    bus(1'b1, OFS_CTRL, 32'h10, q);
    @(negedge clk_sys_i);
    w = line_w;
    h = host_w;
    @(negedge clk_sys_i);
    cmp("proc rx", w, proc_rx_o);
    cmp("proc tx", h, proc_tx_o);
    cmp("host enc", w, host_pcs10_enc_o);
    cmp("line enc", h, line_pcs10_enc_o);
    @(negedge clk_sys_i);
    cmp("loopback", w, serial_tx_output_o);
    $display("path test done");
  endtask : t_path

  task automatic t_fir;
    logic [31:0] q;
    logic [2:0] s;
    logic signed [7:0] e;
    bus(1'b1, OFS_FIR, 32'h0002_1001, q);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk_sys_i);
      s[i] = serial_tx_output_o.dat[0];
    end
    // Newest bit weighs the pre-cursor, oldest the post-cursor
    e = (s[2] ? 8'sh01 : -8'sh01) + (s[1] ? 8'sh10 : -8'sh10)
        + (s[0] ? 8'sh02 : -8'sh02);
    repeat (2) @(negedge clk_sys_i);
    cmp("fir sum", e, fir_sum_o);
    $display("fir test done");
  endtask : t_fir

  task automatic t_an;
    logic [31:0] q;
    bus(1'b1, OFS_CTRL, 32'h80, q);
    @(posedge clk_sys_i);
    rate_det_i <= '{1'b1, 1'b0};
    @(posedge clk_sys_i);
    rate_det_i <= '0;
    link_lost_i <= 1'b1;
    @(negedge clk_sys_i);
    cmp("parallel cru", 1'b0, cru_10g_o);
    @(posedge clk_sys_i);
    link_lost_i <= 1'b0;
    an_partner_i <= '{1'b1, 1'b1};
    @(posedge clk_sys_i);
    an_partner_i <= '0;
    @(negedge clk_sys_i);
    cmp("an cru", 1'b1, cru_10g_o);
    cmp("train en", 1'b1, train_en_o);
    @(posedge clk_sys_i);
    train_done_i <= 1'b1;
    @(posedge clk_sys_i);
    train_done_i <= 1'b0;
    bus(1'b0, OFS_STATUS, '0, q);
    cmp("an good", 1'b1, q[STS_AN_GOOD]);
    bus(1'b1, OFS_CTRL, 32'h180, q);
    repeat (2) @(negedge clk_sys_i);
    cmp("forced cru", 1'b0, cru_10g_o);
    $display("negotiation test done");
  endtask : t_an

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    p_en <= 1'b1;
    @(posedge clk_sys_i);
    t_regs();
    t_mode(2'h1, RATE_9G95);
    t_mode(2'h2, RATE_1G25);
    t_mon(2'h2, 1'b0);
    t_mode(2'h0, RATE_10G3);
    t_mon(2'h0, 1'b1);
    t_path();
    t_fir();
    t_rate();
    t_strap();
    t_an();
    final_report();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    final_report();
  end
endmodule : phy_mode_datapath_steering_bench
